// >>> hw/chan_cfg_defines.vh
// constants for the channel configuration and readback register bank
`ifndef CHAN_CFG_DEFINES_VH
`define CHAN_CFG_DEFINES_VH
`define PROTO_REV_VALUE      8'h11
`define CFG_WIDTH            16
`define CFG_RESET            16'h0000
`define CFG_WR_MASK          16'h0fff
`define CFG_FAST_SERVO_OFF   11
`define CFG_SUP_LORES        10
`define CFG_ADC_HIRES        9
`define CFG_CTRL_SEL         8
`define CFG_SERVO_CONT       7
`define CFG_SERVO_ON_WARN    6
`define CFG_DAC_MODE_HI      5
`define CFG_DAC_MODE_LO      4
`define DAC_MODE_SERVO       2'b00
`define DAC_MODE_OPEN        2'b01
`define DAC_MODE_DIRECT      2'b10
`define DAC_MODE_SOFT        2'b11
`define CMD_TEMP             2'h0
`define CMD_REV              2'h1
`define CMD_CFG              2'h2
`define TEMP_EXP_HI          15
`define TEMP_EXP_LO          11
`endif

// >>> hw/chan_cfg_decode.v
// per-channel decoder of configuration fields into steering controls
`include "chan_cfg_defines.vh"
module chan_cfg_decode #(
  parameter ODD = 0
) (
  input  wire [15:0] cfg,
  input  wire        first_control_pin,
  input  wire        second_control_pin,
  output wire        fast_servo_en,
  output wire        sup_fine_step,
  output wire        adc_fine_step,
  output wire        ctrl_level,
  output wire        dac_connect,
  output wire        dac_soft,
  output wire        dac_direct,
  output wire        servo_en,
  output wire        servo_cont,
  output wire        reservo_warn,
  output wire        wait_rise
);
  wire [1:0] mode;
  assign mode = cfg[`CFG_DAC_MODE_HI:`CFG_DAC_MODE_LO];
  assign fast_servo_en = ~cfg[`CFG_FAST_SERVO_OFF]; // [RL5]
  assign sup_fine_step = ~cfg[`CFG_SUP_LORES]; // [RL6]
  // even channels ignore the bit and stay coarse
  assign adc_fine_step = (ODD != 0) & cfg[`CFG_ADC_HIRES]; // [RL7]
  assign ctrl_level = cfg[`CFG_CTRL_SEL] ? second_control_pin
                                         : first_control_pin; // [RL8]
  assign servo_en   = (mode == `DAC_MODE_SERVO); // [RL11]
  assign servo_cont = servo_en & cfg[`CFG_SERVO_CONT]; // [RL9]
  assign reservo_warn = servo_en & ~cfg[`CFG_SERVO_CONT] &
                        cfg[`CFG_SERVO_ON_WARN]; // [RL10]
  assign wait_rise  = servo_en; // [RL11] [RL12]
  assign dac_connect = (mode != `DAC_MODE_OPEN); // [RL12]
  assign dac_soft   = servo_en | (mode == `DAC_MODE_SOFT); // [RL11] [RL12]
  assign dac_direct = (mode == `DAC_MODE_DIRECT); // [RL12]
endmodule // chan_cfg_decode

// >>> hw/channel_config_and_readback.v
// command register bank: temperature readback, revision, channel config
// How it works
// RL1: temperature reads back as 5-bit exponent over 11-bit mantissa.
// RL2: revision register is read only, fixed at hex 11.
// RL3: each channel keeps its own configuration word.
// RL4: upper four config bits ignore writes and read zero.
// RL5: bit 11 set disables fast servo, clear enables it.
// RL6: bit 10 picks supervisor step 4 mV or 8 mV.
// RL7: bit 9 picks fine adc step, odd channels only.
// RL8: bit 8 picks first or second control pin.
// RL9: bit 7 continuous servo, only in dac mode 00.
// RL10: bit 6 re-servo on warning, mode 00 and no continuous servo.
// RL11: mode 00 soft connects, servos, waits rise time on entry.
// RL12: mode 01 open, 10 direct dac code, 11 soft connect then writes.
`include "chan_cfg_defines.vh"
module channel_config_and_readback #(
  parameter NCH = 8
) (
  input  wire             core_clk,
  input  wire             rstn,
  input  wire [2:0]       page,
  input  wire [1:0]       cmd,
  input  wire             wr_en,
  input  wire             rd_en,
  input  wire [15:0]      wr_data,
  input  wire [4:0]       temp_exp,
  input  wire [10:0]      temp_mant,
  input  wire             temp_valid,
  input  wire             first_control_pin,
  input  wire             second_control_pin,
  output reg  [15:0]      rd_data_ff,
  output reg              rd_valid_ff,
  output reg  [NCH-1:0]   fast_servo_en_ff,
  output reg  [NCH-1:0]   sup_fine_step_ff,
  output reg  [NCH-1:0]   adc_fine_step_ff,
  output reg  [NCH-1:0]   ctrl_level_ff,
  output reg  [NCH-1:0]   dac_connect_ff,
  output reg  [NCH-1:0]   dac_soft_ff,
  output reg  [NCH-1:0]   dac_direct_ff,
  output reg  [NCH-1:0]   servo_en_ff,
  output reg  [NCH-1:0]   servo_cont_ff,
  output reg  [NCH-1:0]   reservo_warn_ff,
  output reg  [NCH-1:0]   wait_rise_ff
);
  reg  [15:0] temp_ff;
  reg  [15:0] cfg_ff [0:NCH-1];
  reg  [2:0]  c0_sync_ff;
  reg  [2:0]  c1_sync_ff;
  reg         c0_ff;
  reg         c1_ff;
  reg  [15:0] nxt_rd_data;
  wire [NCH-1:0] w_fse, w_sup, w_adc, w_ctl, w_con, w_soft, w_dir;
  wire [NCH-1:0] w_sen, w_cont, w_warn, w_rise;
  wire [NCH-1:0] cfg_we;

  // config command decode for the per-channel write strobes
  function cfg_cmd;
    input [1:0] c;
    begin
      cfg_cmd = (c == `CMD_CFG);
    end
  endfunction

  // pins are asynchronous; accept a level once stages two and three agree
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c0_sync_ff <= 3'h0;
      c0_ff      <= 1'b0;
    end else begin
      c0_sync_ff <= {c0_sync_ff[1:0], first_control_pin};
      if (c0_sync_ff[1] == c0_sync_ff[2])
        c0_ff <= c0_sync_ff[2];
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c1_sync_ff <= 3'h0;
      c1_ff      <= 1'b0;
    end else begin
      c1_sync_ff <= {c1_sync_ff[1:0], second_control_pin};
      if (c1_sync_ff[1] == c1_sync_ff[2])
        c1_ff <= c1_sync_ff[2];
    end
  end

  // latest sample held until the next one arrives
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      temp_ff <= 16'h0000;
    else if (temp_valid)
      temp_ff <= {temp_exp, temp_mant}; // [RL1]
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      assign cfg_we[g] = wr_en & cfg_cmd(cmd) & (page == g); // [RL3]
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn)
          cfg_ff[g] <= `CFG_RESET;
        else if (cfg_we[g])
          cfg_ff[g] <= wr_data & `CFG_WR_MASK; // [RL3] [RL4]
      end
      chan_cfg_decode #(.ODD(g % 2)) u_dec (
        .cfg                (cfg_ff[g]),
        .first_control_pin  (c0_ff),
        .second_control_pin (c1_ff),
        .fast_servo_en      (w_fse[g]),
        .sup_fine_step      (w_sup[g]),
        .adc_fine_step      (w_adc[g]),
        .ctrl_level         (w_ctl[g]),
        .dac_connect        (w_con[g]),
        .dac_soft           (w_soft[g]),
        .dac_direct         (w_dir[g]),
        .servo_en           (w_sen[g]),
        .servo_cont         (w_cont[g]),
        .reservo_warn       (w_warn[g]),
        .wait_rise          (w_rise[g])
      );
    end
  endgenerate

  always @* begin
    case (cmd)
      `CMD_TEMP: nxt_rd_data = temp_ff; // [RL1]
      `CMD_REV:  nxt_rd_data = {8'h00, `PROTO_REV_VALUE}; // [RL2]
      `CMD_CFG:  nxt_rd_data = cfg_ff[page] & `CFG_WR_MASK; // [RL4]
      default:   nxt_rd_data = 16'h0000;
    endcase
  end

  // decoded controls registered so every output comes from a flop
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rd_valid_ff <= 1'b0;
    else
      rd_valid_ff <= rd_en;
  end

  // read word holds until the next read, so a slow host can still take it
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rd_data_ff <= 16'h0000;
    else if (rd_en)
      rd_data_ff <= nxt_rd_data;
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      fast_servo_en_ff <= {NCH{1'b0}};
    else
      fast_servo_en_ff <= w_fse; // [RL5]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      sup_fine_step_ff <= {NCH{1'b0}};
    else
      sup_fine_step_ff <= w_sup; // [RL6]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      adc_fine_step_ff <= {NCH{1'b0}};
    else
      adc_fine_step_ff <= w_adc; // [RL7]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      ctrl_level_ff <= {NCH{1'b0}};
    else
      ctrl_level_ff <= w_ctl; // [RL8]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      dac_connect_ff <= {NCH{1'b0}};
    else
      dac_connect_ff <= w_con; // [RL12]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      dac_soft_ff <= {NCH{1'b0}};
    else
      dac_soft_ff <= w_soft; // [RL11]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      dac_direct_ff <= {NCH{1'b0}};
    else
      dac_direct_ff <= w_dir; // [RL12]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      servo_en_ff <= {NCH{1'b0}};
    else
      servo_en_ff <= w_sen; // [RL11]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      servo_cont_ff <= {NCH{1'b0}};
    else
      servo_cont_ff <= w_cont; // [RL9]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      reservo_warn_ff <= {NCH{1'b0}};
    else
      reservo_warn_ff <= w_warn; // [RL10]
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      wait_rise_ff <= {NCH{1'b0}};
    else
      wait_rise_ff <= w_rise; // [RL11]
  end
endmodule // channel_config_and_readback

// >>> verification/chan_cfg_checker.sv
// assertion checker for the config and readback bank
module chan_cfg_checker #(parameter NCH = 8) (
  input            core_clk,
  input            rstn,
  input [2:0]      page,
  input [1:0]      cmd,
  input            wr_en,
  input            rd_en,
  input [15:0]     wr_data,
  input [15:0]     rd_data_ff,
  input [NCH-1:0]  fast_servo_en_ff,
  input [NCH-1:0]  sup_fine_step_ff,
  input [NCH-1:0]  adc_fine_step_ff,
  input [NCH-1:0]  dac_soft_ff,
  input [NCH-1:0]  dac_direct_ff,
  input [NCH-1:0]  servo_en_ff,
  input [NCH-1:0]  servo_cont_ff,
  input [NCH-1:0]  reservo_warn_ff,
  input [NCH-1:0]  wait_rise_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  localparam [NCH-1:0] evn_mask = {NCH/2{2'b01}};
  sequence s_cfg_wr;
    wr_en && cmd == 2'h2;
  endsequence
  a_rev_fixed: assert property (
    rd_en && cmd == 2'h1 |=> rd_data_ff == 16'h0011) else $error("rev");
  a_upper_zero: assert property (
    rd_en && cmd == 2'h2 |=> rd_data_ff[15:12] == 4'h0) else $error("top");
  a_fast_servo: assert property (s_cfg_wr |-> ##2
    fast_servo_en_ff[$past(page, 2)] == (($past(wr_data, 2) & 16'h0800) == 0))
    else $error("fast servo");
  a_sup_step: assert property (s_cfg_wr |-> ##2
    sup_fine_step_ff[$past(page, 2)] == (($past(wr_data, 2) & 16'h0400) == 0))
    else $error("sup step");
  a_adc_even: assert property (
    (adc_fine_step_ff & evn_mask) == 0) else $error("adc even");
  a_cont_mode: assert property (
    (servo_cont_ff & ~servo_en_ff) == 0) else $error("cont");
  a_warn_only: assert property (
    (reservo_warn_ff & (servo_cont_ff | ~servo_en_ff)) == 0)
    else $error("warn");
  a_rise_servo: assert property (
    wait_rise_ff == servo_en_ff && (wait_rise_ff & ~dac_soft_ff) == 0)
    else $error("rise");
  a_dac_excl: assert property (
    (dac_direct_ff & (dac_soft_ff | servo_en_ff)) == 0) else $error("dac");
endmodule // chan_cfg_checker
bind channel_config_and_readback chan_cfg_checker #(.NCH(NCH)) chk_u (
  .core_clk         (core_clk),
  .rstn             (rstn),
  .page             (page),
  .cmd              (cmd),
  .wr_en            (wr_en),
  .rd_en            (rd_en),
  .wr_data          (wr_data),
  .rd_data_ff       (rd_data_ff),
  .fast_servo_en_ff (fast_servo_en_ff),
  .sup_fine_step_ff (sup_fine_step_ff),
  .adc_fine_step_ff (adc_fine_step_ff),
  .dac_soft_ff      (dac_soft_ff),
  .dac_direct_ff    (dac_direct_ff),
  .servo_en_ff      (servo_en_ff),
  .servo_cont_ff    (servo_cont_ff),
  .reservo_warn_ff  (reservo_warn_ff),
  .wait_rise_ff     (wait_rise_ff)
);

// >>> verification/temp_sensor_model.sv
// temperature sensor model feeding samples to the bank
module temp_sensor_model (
  input               core_clk,
  input               go,
  input        [15:0] smp,
  output logic        temp_valid,
  output logic [4:0]  temp_exp,
  output logic [10:0] temp_mant
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {temp_valid, temp_exp, temp_mant} = 0;
  // between samples show the inverse so a stray capture is caught
  always @(posedge core_clk) begin
    temp_valid <= go;
    {temp_exp, temp_mant} <= go ? smp : ~{temp_exp, temp_mant};
  end
endmodule // temp_sensor_model

// >>> verification/testbench.sv
// testbench for the config and readback bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, wr_en, rd_en, go, rd_valid_ff, temp_valid;
  logic first_control_pin, second_control_pin;
  logic [2:0] page;
  logic [1:0] cmd;
  logic [15:0] wr_data, rd_data_ff, smp;
  logic [4:0] temp_exp;
  logic [10:0] temp_mant;
  logic [7:0] fast_servo_en_ff, sup_fine_step_ff, adc_fine_step_ff,
    ctrl_level_ff, dac_connect_ff, dac_soft_ff, dac_direct_ff, servo_en_ff,
    servo_cont_ff, reservo_warn_ff, wait_rise_ff;
  int num_errors, compares, cyc, k;
  channel_config_and_readback dut_u (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .page               (page),
    .cmd                (cmd),
    .wr_en              (wr_en),
    .rd_en              (rd_en),
    .wr_data            (wr_data),
    .temp_exp           (temp_exp),
    .temp_mant          (temp_mant),
    .temp_valid         (temp_valid),
    .first_control_pin  (first_control_pin),
    .second_control_pin (second_control_pin),
    .rd_data_ff         (rd_data_ff),
    .rd_valid_ff        (rd_valid_ff),
    .fast_servo_en_ff   (fast_servo_en_ff),
    .sup_fine_step_ff   (sup_fine_step_ff),
    .adc_fine_step_ff   (adc_fine_step_ff),
    .ctrl_level_ff      (ctrl_level_ff),
    .dac_connect_ff     (dac_connect_ff),
    .dac_soft_ff        (dac_soft_ff),
    .dac_direct_ff      (dac_direct_ff),
    .servo_en_ff        (servo_en_ff),
    .servo_cont_ff      (servo_cont_ff),
    .reservo_warn_ff    (reservo_warn_ff),
    .wait_rise_ff       (wait_rise_ff)
  );
  temp_sensor_model sen_u (
    .core_clk   (core_clk),
    .go         (go),
    .smp        (smp),
    .temp_valid (temp_valid),
    .temp_exp   (temp_exp),
    .temp_mant  (temp_mant)
  );
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [2:0] p, input [1:0] c, input [15:0] d);
    @(posedge core_clk);
    {page, cmd, wr_data, wr_en} <= {p, c, d, 1'b1};
    @(posedge core_clk);
    wr_en <= 0;
  endtask
  task rd(input [2:0] p, input [1:0] c, input [15:0] e);
    @(posedge core_clk);
    {page, cmd, rd_en} <= {p, c, 1'b1};
    @(posedge core_clk);
    rd_en <= 0;
    #1 chk({15'h0, rd_valid_ff}, 16'h0001);
    chk(rd_data_ff, e);
  endtask
  task print_verdict;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    {rstn, wr_en, rd_en, go, first_control_pin, second_control_pin} = 0;
    {page, cmd, wr_data, smp} = 0;
    repeat (3) @(posedge core_clk);
    rstn <= 1;
    rd(0, 1, 16'h0011);
    rd(0, 3, 16'h0000);
    @(posedge core_clk);
    {go, smp} <= {1'b1, 16'hf9a5};
    @(posedge core_clk);
    go <= 0;
    rd(0, 0, 16'hf9a5);
    $display("test 1 done");
    wr(0, 1, 16'hffff);
    rd(0, 2, 16'h0000);
    for (k = 0; k < 8; k++) wr(k, 2, {4'ha, 1'b1, k[2:0], 8'h5a});
    for (k = 0; k < 8; k++) rd(k, 2, {5'h01, k[2:0], 8'h5a});
    chk({8'h0, fast_servo_en_ff}, 16'h0000);
    chk({8'h0, sup_fine_step_ff}, 16'h000f);
    $display("test 2 done");
    for (k = 0; k < 2; k++) begin
      @(posedge core_clk);
      {first_control_pin, second_control_pin} <= {k == 0, k == 1};
      repeat (8) @(posedge core_clk);
      #1 chk({14'h0, ctrl_level_ff[1:0]}, k ? 16'h0002 : 16'h0001);
    end
    $display("test 3 done");
    wr(0, 2, 16'h0200);
    for (k = 0; k < 8; k++) begin
      wr(1, 2, {6'h0, 2'b10, k[2], 1'b1, k[1:0], 4'h0});
      @(posedge core_clk);
      #1 chk({7'h0, dac_connect_ff[1], dac_soft_ff[1], dac_direct_ff[1],
        servo_en_ff[1], wait_rise_ff[1], servo_cont_ff[1], reservo_warn_ff[1],
        adc_fine_step_ff[1:0]}, {7'h0, k[1:0] != 1, k[1:0] == 0 || k[1:0] == 3,
        k[1:0] == 2, k[1:0] == 0, k[1:0] == 0, k == 4, k == 0,
        2'b10});
    end
    $display("test 4 done");
    // reset again in mid-run: every channel must fall back to its reset word
    @(posedge core_clk);
    rstn <= 0;
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    #1 chk({8'h0, fast_servo_en_ff}, 16'h00ff);
    chk({8'h0, sup_fine_step_ff}, 16'h00ff);
    rd(1, 2, 16'h0000);
    $display("test 5 done");
    print_verdict;
  end
endmodule // testbench
